/* File: rsc_reset_source_controller.sv */
// Reset source controller: merges reset sources, drives the shared reset pin, logs causes.
// Function
// - All nine reset sources hold the shared reset pin low for the whole delay phase.
// - When the reset phase ends execution starts at the fixed reset vector 6000h.
// - A long enough low pulse on the reset pin from outside causes an external reset.
// - Any internal source is stretched to a pin low pulse of at least the fixed length.
// - Each internal source sets a cause flag, software reset the window one and option byte mismatch the disturbance one; power-on and brown-out set none.
// - A cause flag stays set until software writes a one to its bit.
// - The power-on detector holds reset until the brown-out detector works, which then holds it.
// - A supply drop below the brown-out threshold resets and re-arms the power-on detector.
// - The brown-out detector stays enabled in every low-power mode.
// - Clearing counter bit 6 of the window watchdog control forces a window watchdog reset.
// - A debug link reset request generates a reset and sets the debug flag.
// - A fetched byte that is neither an opcode nor a prebyte causes a bad opcode reset.
// - A valid prebyte with a valid opcode in an unauthorized pair causes no reset.
// - Complementary register pairs are compared continuously; a mismatch resets.
// - Status holds disturbance at bit 4, then debug, bad opcode, indep and window flags.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_n_i,
  output logic reset_pin_n_o,
  output logic reset_pin_n_oe,
  input wire logic por_supply_low,
  input wire logic brownout_detector_ready,
  input wire logic brownout_detector_low,
  input wire logic indep_watchdog_expire,
  input wire logic window_watchdog_expire,
  input wire logic window_watchdog_control_wr,
  input wire logic [7:0] window_watchdog_control_wdata,
  input wire logic debug_reset_req,
  input wire logic fetch_valid,
  input wire logic fetch_is_opcode,
  input wire logic fetch_is_prebyte,
  input wire logic [`RSC_CRIT_W-1:0] crit_value,
  input wire logic [`RSC_CRIT_W-1:0] crit_compl,
  input wire logic option_byte_mismatch,
  output logic sys_reset_n,
  output logic core_start,
  output logic [15:0] reset_vector,
  output logic por_detector_on,
  output logic irq
);
  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int T_OP_CYC = (`RSC_T_OP_NS * `RSC_CLK_MHZ + 999) / 1000;
  localparam int T_INFP_CYC = (`RSC_T_INFP_NS * `RSC_CLK_MHZ + 999) / 1000;
  localparam logic [`RSC_CNT_W-1:0] OP_LOAD = `RSC_CNT_W'(T_OP_CYC - 1);
  localparam logic [`RSC_CNT_W-1:0] INFP_LAST = `RSC_CNT_W'(T_INFP_CYC - 1);

  // -------------------------------------------------------------------------
  // Synchronisers for pin and analog detector levels
  // -------------------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  wire logic [3:0] async_in = {reset_pin_n_i, por_supply_low, brownout_detector_ready,
                               brownout_detector_low};
  // Two flops per asynchronous level; only the second stage is read by logic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end
  wire logic pin_s = sync_b[3];
  wire logic por_low_s = sync_b[2];
  wire logic bor_ready_s = sync_b[1];
  wire logic bor_low_s = sync_b[0];

  // -------------------------------------------------------------------------
  // Power-on and brown-out supervision
  // -------------------------------------------------------------------------
  logic por_active;
  // Power-on detector runs until the brown-out detector works, and re-arms on a drop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_active <= 1'b1;
    end else if (bor_low_s) begin
      por_active <= 1'b1;
    end else if (bor_ready_s) begin
      por_active <= 1'b0;
    end
  end
  // The brown-out term has no low-power gating, so it acts in every mode.
  wire logic supply_hold = (por_active & por_low_s) | bor_low_s | (por_active & !bor_ready_s);
  assign por_detector_on = por_active;

  // -------------------------------------------------------------------------
  // Internal reset sources
  // -------------------------------------------------------------------------
  rsc_cause_s cause_trig;
  wire logic sw_reset = window_watchdog_control_wr
                        & !window_watchdog_control_wdata[`RSC_WINDOW_WATCHDOG_T6];
  // Only the two decode results matter, so a legal but unauthorized pair never trips.
  wire logic bad_fetch = fetch_valid & !fetch_is_opcode & !fetch_is_prebyte;
  wire logic compl_bad = (crit_value != ~crit_compl) | option_byte_mismatch;
  assign cause_trig.window_wd = window_watchdog_expire | sw_reset;
  assign cause_trig.indep_wd = indep_watchdog_expire;
  assign cause_trig.bad_opcode = bad_fetch;
  assign cause_trig.debug = debug_reset_req;
  assign cause_trig.disturbance = compl_bad;
  wire logic int_trig = |cause_trig;

  // -------------------------------------------------------------------------
  // External pin filter
  // -------------------------------------------------------------------------
  logic [`RSC_CNT_W-1:0] low_cnt;
  wire logic ext_trig = !pin_s && (low_cnt == INFP_LAST) && !reset_pin_n_oe;
  // Counts how long the pin has been low while nobody inside drives it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= '0;
    end else if (pin_s || reset_pin_n_oe) begin
      low_cnt <= '0;
    end else if (low_cnt != INFP_LAST) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Reset sequencer
  // -------------------------------------------------------------------------
  rsc_state_e state;
  rsc_state_e next_state;
  logic [`RSC_CNT_W-1:0] op_cnt;
  wire logic any_trig = int_trig | ext_trig | supply_hold;
  // Every source restarts the drive phase; the pin is then waited on before release.
  always_comb begin
    next_state = state;
    case (state)
      RSC_RUN: begin
        if (any_trig) begin
          next_state = RSC_DRIVE;
        end
      end
      RSC_DRIVE: begin
        if (!any_trig && op_cnt == '0) begin
          next_state = RSC_WAIT;
        end
      end
      RSC_WAIT: begin
        if (any_trig) begin
          next_state = RSC_DRIVE;
        end else if (pin_s) begin
          next_state = RSC_RUN;
        end
      end
      default: next_state = RSC_DRIVE;
    endcase
  end
  // State and stretch counter; a new trigger reloads the full pulse length.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= RSC_DRIVE;
      op_cnt <= OP_LOAD;
    end else begin
      state <= next_state;
      op_cnt <= any_trig ? OP_LOAD : (op_cnt != '0 ? op_cnt - 1'b1 : op_cnt);
    end
  end
  // Open-drain pin: low is driven throughout the drive phase, never high.
  assign reset_pin_n_o = 1'b0;
  assign reset_pin_n_oe = (state == RSC_DRIVE);
  assign sys_reset_n = (state == RSC_RUN);
  logic start_q;
  // One-cycle start strobe on release, with the fixed vector beside it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= (state == RSC_WAIT) && (next_state == RSC_RUN);
    end
  end
  assign core_start = start_q;
  assign reset_vector = `RSC_VECTOR;

  // -------------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------------
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic bvalid;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [1:0] bresp;
  assign s_axi_awready = !aw_hold && !bvalid;
  assign s_axi_wready = !w_hold && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic wr_go = aw_hold && w_hold && !bvalid;
  wire logic wr_stat = wr_go && aw_addr == `RSC_OFF_STATUS && w_lane0;
  wire logic wr_mask = wr_go && aw_addr == `RSC_OFF_IRQ_MASK && w_lane0;
  wire logic wr_known = aw_addr == `RSC_OFF_STATUS || aw_addr == `RSC_OFF_IRQ_MASK
                        || aw_addr == `RSC_OFF_IRQ_STAT;
  wire logic [7:0] ar_off = s_axi_araddr[7:0];
  wire logic ar_known = s_axi_araddr[31:8] == 24'h00_0000 && (ar_off == `RSC_OFF_STATUS
                        || ar_off == `RSC_OFF_IRQ_STAT || ar_off == `RSC_OFF_IRQ_MASK);
  // Address and data are caught separately; the response follows once both are held.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RSC_RESP_OK;
    end else begin
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_addr <= (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
      end
      if (w_take) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? `RSC_RESP_OK : `RSC_RESP_ERR;
      end else if (bvalid && s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registers: cause flags, event status and mask
  // -------------------------------------------------------------------------
  rsc_cause_s reset_status;
  logic [`RSC_EVT_W-1:0] irq_status;
  logic [`RSC_EVT_W-1:0] irq_mask;
  // A write of one clears a flag; a new cause in the same cycle wins. Bits 7:5 are dropped.
  wire rsc_cause_s clr_cause = wr_stat ? w_data[`RSC_CAUSE_W-1:0] : '0;
  wire logic [`RSC_EVT_W-1:0] evt = {supply_hold & sys_reset_n, ext_trig, cause_trig};
  wire logic rd_irq = ar_take && ar_known && ar_off == `RSC_OFF_IRQ_STAT;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_status <= '0;
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      reset_status <= (reset_status & ~clr_cause) | cause_trig;
      irq_status <= (rd_irq ? '0 : irq_status) | evt;
      if (wr_mask) begin
        irq_mask <= w_data[`RSC_EVT_W-1:0];
      end
    end
  end
  assign irq = |(irq_status & irq_mask);
  // Read path; unmapped addresses answer an error with zero data.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RSC_RESP_OK;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rresp <= ar_known ? `RSC_RESP_OK : `RSC_RESP_ERR;
      rdata <= !ar_known ? 32'h0000_0000 :
               ar_off == `RSC_OFF_STATUS ? {27'h0, reset_status} :
               ar_off == `RSC_OFF_IRQ_STAT ? {25'h0, irq_status} : {25'h0, irq_mask};
    end else if (rvalid && s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  logic [`RSC_CNT_W-1:0] drive_len;
  // Length of the current pin drive, for the pulse width check.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_len <= '0;
    end else begin
      drive_len <= reset_pin_n_oe ? drive_len + 1'b1 : '0;
    end
  end
  a_pin_drive_low: assert property (@(posedge clk) disable iff (!rstn)
    (state != RSC_RUN && any_trig) |=> reset_pin_n_oe && !reset_pin_n_o)
    else $error("reset pin not driven low during reset phase");
  a_start_vector: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sys_reset_n) |-> core_start && reset_vector == `RSC_VECTOR)
    else $error("start without fixed vector");
  a_ext_reset_take: assert property (@(posedge clk) disable iff (!rstn)
    ext_trig |=> state == RSC_DRIVE && !sys_reset_n)
    else $error("filtered pin low did not reset");
  a_pulse_min_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(reset_pin_n_oe) |-> drive_len >= `RSC_CNT_W'(T_OP_CYC))
    else $error("reset pin pulse too short");
  a_cause_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    cause_trig.bad_opcode |=> reset_status.bad_opcode ##0 state == RSC_DRIVE)
    else $error("bad opcode cause not logged");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (reset_status.debug && !(wr_stat && w_data[3])) |=> reset_status.debug)
    else $error("debug flag lost without a clear");
  a_zero_write_keep: assert property (@(posedge clk) disable iff (!rstn)
    (wr_stat && !w_data[0] && reset_status.window_wd) |=> reset_status.window_wd)
    else $error("zero write cleared a flag");
  a_supply_hold: assert property (@(posedge clk) disable iff (!rstn)
    supply_hold |=> !sys_reset_n [*2])
    else $error("reset released while supply low");
  a_por_rearm: assert property (@(posedge clk) disable iff (!rstn)
    bor_low_s |=> por_active && por_detector_on)
    else $error("power-on detector not re-armed");
  a_sw_reset: assert property (@(posedge clk) disable iff (!rstn)
    sw_reset |=> reset_status.window_wd && reset_pin_n_oe)
    else $error("software reset not taken");
  a_compl_check: assert property (@(posedge clk) disable iff (!rstn)
    (crit_value != ~crit_compl) |=> reset_status.disturbance && !sys_reset_n)
    else $error("complement mismatch not caught");
  c_ext_reset: cover property (@(posedge clk) disable iff (!rstn)
    ext_trig ##[1:1000] core_start);
  c_debug_reset: cover property (@(posedge clk) disable iff (!rstn)
    debug_reset_req ##[1:1000] core_start);
  c_flag_clear: cover property (@(posedge clk) disable iff (!rstn)
    reset_status.indep_wd ##1 !reset_status.indep_wd);
  c_irq_raise: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
endmodule

/* File: rsc_cfg.svh */
// Constants of the reset source controller: offsets, fields, timing, encodings.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_MHZ 20
`define RSC_T_OP_NS 20000
`define RSC_T_INFP_NS 500
`define RSC_VECTOR 16'h6000
`define RSC_OFF_STATUS 8'h00
`define RSC_OFF_IRQ_STAT 8'h04
`define RSC_OFF_IRQ_MASK 8'h08
`define RSC_CAUSE_W 5
`define RSC_EVT_W 7
`define RSC_EVT_PIN 5
`define RSC_EVT_BROWN 6
`define RSC_WINDOW_WATCHDOG_T6 6
`define RSC_CRIT_W 8
`define RSC_RESP_OK 2'h0
`define RSC_RESP_ERR 2'h2
`define RSC_CNT_W 16
`endif

/* File: rsc_pkg.sv */
// Types shared by the reset source controller.
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_RUN = 2'b00,
    RSC_DRIVE = 2'b01,
    RSC_WAIT = 2'b10
  } rsc_state_e;
  // Reset cause flags, packed in status register bit order (bit 4 down to bit 0).
  typedef struct packed {
    logic disturbance;
    logic debug;
    logic bad_opcode;
    logic indep_wd;
    logic window_wd;
  } rsc_cause_s;
endpackage

/* File: rsc_pin_partner.sv */
// Outside device that shares the open-drain reset pin, with the pin's weak pull-up.
`timescale 1ns/1ps
module rsc_pin_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pull_req,
  input wire logic [7:0] pull_len,
  input wire logic dev_oe,
  input wire logic dev_o,
  output logic pin_level
);
  logic [7:0] left;
  // Counts down the low pulse that the outside device drives on request.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left <= 8'h00;
    end else if (pull_req) begin
      left <= pull_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Both drivers only pull low, so the pull-up gives a high level when nobody drives.
  assign pin_level = !((dev_oe && !dev_o) || (left != 8'h00));
endmodule

/* File: rsc_reset_source_controller_bench.sv */
// Self-checking bench of the reset source controller with a pin partner and a bus master.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_reset_source_controller_bench;
  // ----------
  // Signals and model state
  // ----------
  logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reset_pin_n_i, reset_pin_n_o, reset_pin_n_oe, por_supply_low, brownout_detector_ready;
  logic brownout_detector_low, indep_watchdog_expire, window_watchdog_expire, debug_reset_req;
  logic window_watchdog_control_wr, fetch_valid, fetch_is_opcode, fetch_is_prebyte;
  logic option_byte_mismatch, sys_reset_n, core_start, por_detector_on, irq, pull_req;
  logic [7:0] window_watchdog_control_wdata, pull_len;
  logic [`RSC_CRIT_W-1:0] crit_value, crit_compl;
  logic [15:0] reset_vector;
  logic [31:0] seed = 32'hf090_c7e7;
  int errors = 0, n_checks = 0, exp_status = 0;
  int flag_of [0:6] = '{1, 2, 4, 8, 16, 16, 1};

  rsc_reset_source_controller dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reset_pin_n_i, .reset_pin_n_o, .reset_pin_n_oe,
    .por_supply_low, .brownout_detector_ready, .brownout_detector_low, .indep_watchdog_expire,
    .window_watchdog_expire, .window_watchdog_control_wr, .window_watchdog_control_wdata,
    .debug_reset_req, .fetch_valid, .fetch_is_opcode, .fetch_is_prebyte, .crit_value,
    .crit_compl, .option_byte_mismatch, .sys_reset_n, .core_start, .reset_vector,
    .por_detector_on, .irq);
  rsc_pin_partner partner (.clk, .rstn, .pull_req, .pull_len, .dev_oe(reset_pin_n_oe),
    .dev_o(reset_pin_n_o), .pin_level(reset_pin_n_i));

  // The 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cuts a hung run short, well beyond the length of the whole sequence.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
  // ----------
  // Tasks
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bus write: address and data offered together, each dropped once taken.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // Quiet reset sources; the complementary pair gets a fresh random matching value.
  task automatic idle();
    seed = xs(seed);
    {indep_watchdog_expire, window_watchdog_expire, window_watchdog_control_wr, debug_reset_req,
      fetch_valid, fetch_is_opcode, fetch_is_prebyte, option_byte_mismatch} <= '0;
    crit_value <= seed[7:0];
    crit_compl <= ~seed[7:0];
  endtask
  // One cycle of a source: 0 to 6 reset, 7 to 10 are legal look-alikes.
  task automatic pulse(input int k);
    seed = xs(seed);
    case (k)
      0: window_watchdog_expire <= 1'b1;
      1: indep_watchdog_expire <= 1'b1;
      2: fetch_valid <= 1'b1;
      3: debug_reset_req <= 1'b1;
      4: crit_compl <= crit_value;
      5: option_byte_mismatch <= 1'b1;
      6, 10: begin
        window_watchdog_control_wr <= 1'b1;
        window_watchdog_control_wdata <= (k == 6) ? (seed[7:0] & 8'hbf) : (seed[7:0] | 8'h40);
      end
      default: {fetch_valid, fetch_is_opcode, fetch_is_prebyte} <= {1'b1, 2'(k - 6)};
    endcase
    @(posedge clk);
    idle();
    @(posedge clk);
  endtask
  // Checks the pin is driven, then waits for release and the single start pulse.
  task automatic wait_run(input int min_cyc);
    int n;
    n = 0;
    compare("drive_low", 32'h2, {sys_reset_n, reset_pin_n_oe, reset_pin_n_o});
    while (sys_reset_n !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    compare("reset_long", 1, n >= min_cyc);
    // The start strobe rises together with the internal reset release.
    compare("start_pulse", 1, core_start);
    @(posedge clk);
    compare("start_once", 0, core_start);
  endtask
  task automatic check_regs(input logic [31:0] evt);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(`RSC_OFF_STATUS, d, r);
    compare("status", exp_status, d);
    axi_read(`RSC_OFF_IRQ_STAT, d, r);
    compare("events", evt, d);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    int i;
    logic [31:0] d, wd;
    logic [1:0] r;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {por_supply_low, brownout_detector_ready, brownout_detector_low, pull_req} = '0;
    {window_watchdog_control_wdata, pull_len} = '0;
    idle();
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (500) @(posedge clk);
    compare("held_reset", 32'h3, {sys_reset_n, por_detector_on, reset_pin_n_oe});
    brownout_detector_ready <= 1'b1;
    wait_run(400);
    compare("por_off", 0, por_detector_on);
    compare("vector", `RSC_VECTOR, reset_vector);
    check_regs(0);
    // Each internal source in turn: flag, event, masking and the write-one clear.
    for (i = 0; i < 7; i++) begin
      axi_write(`RSC_OFF_IRQ_MASK, (i == 6) ? 32'h0 : 32'h7f, r);
      seed = xs(seed);
      repeat (seed[2:0]) @(posedge clk);
      pulse(i);
      wait_run(395);
      exp_status = exp_status | flag_of[i];
      compare("irq", i != 6, irq);
      check_regs(flag_of[i]);
      compare("irq_clear", 0, irq);
      wd = seed & 32'hffff_ffe0;
      repeat (2) begin
        axi_write(`RSC_OFF_STATUS, wd, r);
        exp_status = exp_status & ~(wd & 32'h1f);
        axi_read(`RSC_OFF_STATUS, d, r);
        compare("status_w1c", exp_status, d);
        wd = wd | flag_of[i];
      end
    end
    for (i = 7; i < 11; i++) pulse(i);
    repeat (20) @(posedge clk);
    compare("no_reset", 32'h2, {sys_reset_n, reset_pin_n_oe});
    // Outside pin pulses, first shorter and then longer than the filter.
    pull_len <= 8'h05;
    pull_req <= 1'b1;
    @(posedge clk);
    pull_req <= 1'b0;
    repeat (20) @(posedge clk);
    compare("short_pin", 1, sys_reset_n);
    pull_len <= 8'h0e;
    pull_req <= 1'b1;
    @(posedge clk);
    pull_req <= 1'b0;
    repeat (20) @(posedge clk);
    wait_run(300);
    check_regs(32'h20);
    brownout_detector_low <= 1'b1;
    repeat (6) @(posedge clk);
    compare("por_rearmed", 32'h1, {sys_reset_n, por_detector_on});
    brownout_detector_low <= 1'b0;
    wait_run(300);
    compare("por_off_again", 0, por_detector_on);
    check_regs(32'h40);
    axi_read(32'h0000_000c, d, r);
    compare("unmapped_rresp", `RSC_RESP_ERR, r);
    compare("unmapped_rdata", 0, d);
    axi_write(32'h0000_0100, 32'h1f, r);
    compare("unmapped_bresp", `RSC_RESP_ERR, r);
    final_report();
  end
endmodule
